//--- shared/nested_irq_map.svh
// Register offsets, field positions, reset values and vector addresses
`ifndef NESTED_IRQ_MAP_SVH
`define NESTED_IRQ_MAP_SVH

// Bus register byte offsets
`define OFS_LEVEL_0 8'h00
`define OFS_LEVEL_1 8'h04
`define OFS_LEVEL_2 8'h08
`define OFS_LEVEL_3 8'h0C
`define OFS_PIN_CTRL 8'h10
`define OFS_FLAGS 8'h14

// Reset values
`define FLAGS_RESET 8'hEA
`define LEVEL_RESET 8'hFF
`define PIN_CTRL_RESET 8'h00
`define LEVEL_3_RO_MASK 8'hF0

// Priority bit positions in the condition flags
`define FLAG_LEVEL_HIGH 5
`define FLAG_LEVEL_LOW 3

// Pin control field positions
`define SENSE_23_HI 7
`define SENSE_23_LO 6
`define POL_B_BIT 5
`define SENSE_01_HI 4
`define SENSE_01_LO 3
`define POL_A_BIT 2
`define TOP_EDGE_BIT 1
`define TOP_EN_BIT 0

// Level encodings
`define LVL_MAIN 2'h2
`define LVL_ONE 2'h1
`define LVL_TWO 2'h0
`define LVL_OFF 2'h3

// Vector addresses and numbers
`define VEC_RESET 16'hFFFE
`define VEC_TRAP 16'hFFFC
`define VEC_TOP 16'hFFFA
`define NUM_VECTORS 14
`define V_TIME_BASE 1
`define V_GROUP_0 2
`define V_GROUP_1 3
`define V_GROUP_2 4
`define V_GROUP_3 5
`define V_CAN 6
`define V_SPI 7
`define V_PWM 13

`endif

//--- shared/nested_irq_pkg.sv
// Types and shared functions of the nested interrupt controller
package nested_irq_pkg;
   typedef logic [1:0] level_t;

   typedef enum logic [1:0] {
      SENSE_FALL_LOW = 2'h0,
      SENSE_RISE = 2'h1,
      SENSE_FALL = 2'h2,
      SENSE_BOTH = 2'h3
   } sense_t;

   typedef enum logic [2:0] {
      SRC_NONE = 3'h0,
      SRC_RESET = 3'h1,
      SRC_TRAP = 3'h2,
      SRC_TOP = 3'h3,
      SRC_VECTOR = 3'h4
   } src_t;

   // Numeric order of a level code, main lowest
   function automatic logic [1:0] level_rank(input level_t l);
      case (l)
         2'h2: level_rank = 2'h0;
         2'h1: level_rank = 2'h1;
         2'h0: level_rank = 2'h2;
         default: level_rank = 2'h3;
      endcase
   endfunction
endpackage

//--- testbench/core_ack_model.sv
// Core side model: acknowledges a presented vector after a few cycles
module core_ack_model #(
   parameter int ACK_DELAY = 2
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Vector handshake
   input wire logic irq_req,
   output logic irq_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   // Slow acknowledge, so the vector stands for a while before entry
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 0;
         irq_ack <= 1'b0;
      end else begin
         irq_ack <= 1'b0;
         if (irq_req && !irq_ack) begin
            cnt <= (cnt == ACK_DELAY) ? 0 : cnt + 1;
            irq_ack <= (cnt == ACK_DELAY);
         end else cnt <= 0;
      end
   end
endmodule // core_ack_model

//--- testbench/tb.sv
// Register and vector tests of the nested interrupt controller
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, irq_ack, irq_req, top = 0, hreadyout;
   logic hresp, wake, ctb = 0, som = 0, hktb = 0, spi = 0, pwmx = 0;
   logic [3:0] g0 = 0, g0e = 0, g2 = 0, g2e = 0, g3 = 0, g3e = 0, vnum_seen;
   logic [2:0] g1 = 0, g1e = 0;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_val;
   logic [6:0] instr = 0;
   logic [7:0] stacked = 0, preq = 0, flags;
   logic [3:0] vnum;
   logic [15:0] vaddr;
   logic jm, jnm;
   int n_fail = 0, samples_checked = 0;
   always #12.5 hclk = ~hclk;
   nested_priority_interrupt_ctrl nested_priority_interrupt_ctrl_i (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .enable_irq_instr(instr[0]), .disable_irq_instr(instr[1]),
      .trap_instr(instr[2]), .halt_instr(instr[3]), .wait_for_irq_instr(instr[4]),
      .irq_return_instr(instr[5]), .pop_condition_flags(instr[6]), .stacked_flags(stacked),
      .alu_flags_we(1'b0), .alu_flags(8'h00), .irq_ack(irq_ack), .irq_req(irq_req),
      .irq_vector_num(vnum), .irq_vector_addr(vaddr), .cpu_condition_flags(flags),
      .jump_if_masked(jm), .jump_if_unmasked(jnm), .wake_from_halt(wake),
      .top_level_pin_irq(top), .pin_group_0(g0), .pin_group_0_en(g0e),
      .pin_group_1(g1), .pin_group_1_en(g1e), .pin_group_2(g2), .pin_group_2_en(g2e),
      .pin_group_3(g3), .pin_group_3_en(g3e), .clock_time_base(ctb),
      .safe_oscillator_monitor(som), .periph_req(preq), .halt_keeps_time_base(hktb),
      .spi_slave_mode(spi), .pwm_external_clock(pwmx));
   core_ack_model core_ack_model_i (.hclk(hclk), .hresetn(hresetn), .irq_req(irq_req),
      .irq_ack(irq_ack));
   // One AHB-Lite single word transfer, address phase held until hready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0; hsel <= 1'b0; hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_val = hrdata;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      chk(rd_val, {24'h0, e});
   endtask
   // Instruction pulse, then let flags and jump conditions settle
   task automatic pulse(input int k);
      @(posedge hclk) instr <= 7'h01 << k;
      @(posedge hclk) instr <= 7'h00;
      repeat (2) @(posedge hclk);
   endtask
   // Bounded wait for a vector, check it, then let the core enter
   task automatic vec(input logic [15:0] a, input logic [7:0] f);
      repeat (20) if (irq_req !== 1'b1) @(posedge hclk);
      chk(vaddr, a);
      vnum_seen = vnum;
      repeat (8) @(posedge hclk);
      chk(flags, f);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #100us;
      n_fail++;
      end_sim;
   end
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      vec(16'hFFFE, 8'hEA);
      chk(jm, 1'b1);
      rd(8'h14, 8'hEA);
      rd(8'h00, 8'hFF);
      rd(8'h0C, 8'hFF);
      xfer(1'b1, 8'h00, 8'hCF);
      xfer(1'b1, 8'h00, 8'h64);
      rd(8'h00, 8'h44);
      xfer(1'b1, 8'h0C, 8'h00);
      rd(8'h0C, 8'hF0);
      rd(8'h40, 8'h00);
      xfer(1'b1, 8'h10, 8'h01);
      xfer(1'b1, 8'h10, 8'h03);
      rd(8'h10, 8'h01);
      chk(hresp, 1'b0);
      $display("register test done");
      xfer(1'b1, 8'h04, 8'hDF);
      pulse(0);
      chk(flags, 8'hE2);
      chk(jnm, 1'b1);
      preq <= 8'h01;
      vec(16'hFFEE, 8'hCA);
      chk(vnum_seen, 4'h6);
      preq <= 8'h00;
      stacked <= 8'hE2;
      pulse(5);
      chk(flags, 8'hE2);
      pulse(1);
      chk(flags, 8'hEA);
      top <= 1'b1;
      repeat (2) @(posedge hclk);
      top <= 1'b0;
      vec(16'hFFFA, 8'hEA);
      g0 <= 4'h1;
      g0e <= 4'h1;
      xfer(1'b1, 8'h10, 8'h11);
      g0 <= 4'h0;
      repeat (3) @(posedge hclk);
      chk(wake, 1'b1);
      chk(irq_req, 1'b0);
      pulse(0);
      vec(16'hFFF6, 8'hC2);
      chk(wake, 1'b0);
      $display("vector test done");
      end_sim;
   end
endmodule // tb

//--- verilog/nested_priority_interrupt_ctrl.sv
// Nested priority interrupt controller with AHB-Lite register access
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`include "nested_irq_map.svh"

// Behaviour
// [R1] Current level lives in condition flag bits 5 and 3, four coded levels.
// [R2] Condition flags reset to 111x1010, so the core starts at level 3.
// [R3] Entering a maskable vector loads the flag level from its stored level.
// [R4] Enable, halt and wait load 10; disable and trap 11; return restores.
// [R5] Top pin, trap and reset are still taken at level 3.
// [R6] Four 8-bit vector level registers reset to all ones.
// [R7] Upper nibble of the fourth level register reads one, read only.
// [R8] Vector x owns a two-bit field, four per register from vector 0.
// [R9] Writing the main level pattern into a field leaves that field unchanged.
// [R10] Top pin, reset and trap have fixed priority and set level 3.
// [R11] Top pin level field is plain storage, ignored by arbitration.
// [R12] Raising a serviced pending vector's level re-enters it at once.
// [R13] Two jump conditions: level equals 11, and level differs from 11.
// [R14] Inside a routine those instructions change the level until return.
// [R15] Fixed vector addresses descend by two; lower number wins ties.
// [R16] Only listed sources wake from halt.
// [R17] Vector 1 is shared and wakes only from halt keeping the time base.
// [R18] Groups sense four modes; groups 0 and 2 also rising with high level.
// [R19] Four independent sensitivity settings for the pin groups on vectors 2-5; the code shares one sense field per pair, groups 0/1 and 2/3.
// [R20] Software changes sensitivity only while interrupts sit at level 3.
// [R21] Changing a group's sensitivity or polarity clears its pending request.
// [R22] Sense code: 00 falling+low, 01 rising, 10 falling, 11 both edges.
// [R23] Polarity bit inverts group 0 or group 2 sensitivity.
// [R24] Top pin enable gates it; edge select changes only while disabled.
// [R25] Edge requests latch and clear on service entry; group pins are ORed.
// [R26] Pick highest level above current among pending, lowest number on ties.
// [R27] Level register writes land on the next edge; reads have no side effect.
module nested_priority_interrupt_ctrl
   import nested_irq_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Core instruction events
   input wire logic enable_irq_instr,
   input wire logic disable_irq_instr,
   input wire logic trap_instr,
   input wire logic halt_instr,
   input wire logic wait_for_irq_instr,
   input wire logic irq_return_instr,
   input wire logic pop_condition_flags,
   input wire logic [7:0] stacked_flags,
   input wire logic alu_flags_we,
   input wire logic [7:0] alu_flags,
   // Core vector handshake
   input wire logic irq_ack,
   output logic irq_req,
   output logic [3:0] irq_vector_num,
   output logic [15:0] irq_vector_addr,
   output logic [7:0] cpu_condition_flags,
   output logic jump_if_masked,
   output logic jump_if_unmasked,
   output logic wake_from_halt,
   // Request sources
   input wire logic top_level_pin_irq,
   input wire logic [3:0] pin_group_0,
   input wire logic [3:0] pin_group_0_en,
   input wire logic [2:0] pin_group_1,
   input wire logic [2:0] pin_group_1_en,
   input wire logic [3:0] pin_group_2,
   input wire logic [3:0] pin_group_2_en,
   input wire logic [3:0] pin_group_3,
   input wire logic [3:0] pin_group_3_en,
   input wire logic clock_time_base,
   input wire logic safe_oscillator_monitor,
   input wire logic [13:6] periph_req,
   // Wake qualifiers
   input wire logic halt_keeps_time_base,
   input wire logic spi_slave_mode,
   input wire logic pwm_external_clock
);
   logic [3:0][7:0] vector_level_regs;
   logic [7:0] pin_irq_control;
   logic reset_pend;
   logic trap_pend;
   logic top_pend;
   logic top_prev;
   logic [3:0] group_pend;
   logic [3:0] group_clear;
   logic [3:0] group_any;
   logic [13:0] vec_pend;
   src_t irq_kind;
   src_t next_kind;
   logic found_vec;
   logic [3:0] best_num;
   logic [1:0] best_rank;
   logic [1:0] cur_rank;
   level_t cur_level;
   level_t served_level;
   logic [15:0] next_addr;
   logic bus_take;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [7:0] wdata;
   logic [31:0] rd_data;
   logic cfg_wr;
   logic top_edge;
   logic [3:0] group_on;

   // Level field of one vector from the packed level registers
   function automatic level_t level_of(input logic [31:0] regs, input logic [3:0] num);
      level_of = regs[{num, 1'b0} +: 2]; // [R8]
   endfunction

   // Merge a written byte, keeping any field written with the main pattern
   function automatic logic [7:0] merge_level(input logic [7:0] old, input logic [7:0] nw);
      merge_level = old;
      for (int f = 0; f < 4; f++) begin
         if (nw[2*f +: 2] != `LVL_MAIN) begin
            merge_level[2*f +: 2] = nw[2*f +: 2]; // [R9]
         end
      end
   endfunction

   // Pin level that never requests in a mode, shown by a group with no pin enabled
   function automatic logic quiet_level(input logic [1:0] sense, input logic inv);
      quiet_level = (sense != SENSE_RISE) ^ inv;
   endfunction

   // Address of maskable vector n
   function automatic logic [15:0] vec_addr(input logic [3:0] num);
      vec_addr = `VEC_TOP - {11'h000, num, 1'b0}; // [R15]
   endfunction

   assign cur_level = {cpu_condition_flags[`FLAG_LEVEL_HIGH],
                       cpu_condition_flags[`FLAG_LEVEL_LOW]}; // [R1]
   assign cur_rank = level_rank(cur_level);
   assign served_level = level_of(vector_level_regs, irq_vector_num);

   // Bus address phase; zero wait states, data registered at address phase
   assign bus_take = hsel & htrans[1] & hready;
   assign wdata = hwdata[7:0];
   assign cfg_wr = wr_pend && (wr_addr == `OFS_PIN_CTRL);

   always_comb begin
      rd_data = 32'h0000_0000;
      if (haddr[31:8] == 24'h000000) begin
         case (haddr[7:0])
            `OFS_LEVEL_0: rd_data[7:0] = vector_level_regs[0];
            `OFS_LEVEL_1: rd_data[7:0] = vector_level_regs[1];
            `OFS_LEVEL_2: rd_data[7:0] = vector_level_regs[2];
            `OFS_LEVEL_3: rd_data[7:0] = vector_level_regs[3] | `LEVEL_3_RO_MASK; // [R7]
            `OFS_PIN_CTRL: rd_data[7:0] = pin_irq_control;
            `OFS_FLAGS: rd_data[7:0] = cpu_condition_flags;
            default: rd_data = 32'h0000_0000;
         endcase
      end
   end

   // Bus slave handshake; answer is always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend <= bus_take & hwrite & (haddr[31:8] == 24'h000000);
         wr_addr <= haddr[7:0];
         if (bus_take && !hwrite) begin
            hrdata <= rd_data; // [R27]
         end
      end
   end

   // Level registers; unmapped and level-0 field writes are dropped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vector_level_regs <= {4{`LEVEL_RESET}}; // [R6]
      end else if (wr_pend) begin
         for (int r = 0; r < 4; r++) begin
            if (wr_addr == `OFS_LEVEL_0 + 8'(4 * r)) begin
               vector_level_regs[r] <= merge_level(vector_level_regs[r], wdata); // [R27] [R9]
            end
         end
      end
   end

   // Pin control; top edge select frozen while the top pin is enabled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_irq_control <= `PIN_CTRL_RESET;
      end else if (cfg_wr) begin
         pin_irq_control[7:2] <= wdata[7:2]; // [R19]
         pin_irq_control[`TOP_EN_BIT] <= wdata[`TOP_EN_BIT];
         if (!pin_irq_control[`TOP_EN_BIT]) begin
            pin_irq_control[`TOP_EDGE_BIT] <= wdata[`TOP_EDGE_BIT]; // [R24]
         end
      end
   end

   // Config change clears the affected groups; writes at other levels are software's fault
   always_comb begin
      group_clear = 4'h0;
      if (cfg_wr) begin // [R20]
         group_clear[0] = (wdata[`SENSE_01_HI:`SENSE_01_LO]
                           != pin_irq_control[`SENSE_01_HI:`SENSE_01_LO])
                          | (wdata[`POL_A_BIT] != pin_irq_control[`POL_A_BIT]); // [R21]
         group_clear[1] = wdata[`SENSE_01_HI:`SENSE_01_LO]
                          != pin_irq_control[`SENSE_01_HI:`SENSE_01_LO]; // [R21]
         group_clear[2] = (wdata[`SENSE_23_HI:`SENSE_23_LO]
                           != pin_irq_control[`SENSE_23_HI:`SENSE_23_LO])
                          | (wdata[`POL_B_BIT] != pin_irq_control[`POL_B_BIT]); // [R21]
         group_clear[3] = wdata[`SENSE_23_HI:`SENSE_23_LO]
                          != pin_irq_control[`SENSE_23_HI:`SENSE_23_LO]; // [R21]
      end
      for (int g = 0; g < 4; g++) begin
         if (!group_on[g] || (irq_ack && irq_kind == SRC_VECTOR
             && irq_vector_num == 4'(`V_GROUP_0 + g))) begin
            group_clear[g] = 1'b1; // [R25]
         end
      end
   end

   // Enabled pins of a group share one line; an idle group must not look like a low level
   assign group_on = {|pin_group_3_en, |pin_group_2_en, |pin_group_1_en, |pin_group_0_en};
   assign group_any[0] = group_on[0] ? |(pin_group_0 & pin_group_0_en)
                         : quiet_level(pin_irq_control[`SENSE_01_HI:`SENSE_01_LO],
                                       pin_irq_control[`POL_A_BIT]); // [R25]
   assign group_any[1] = group_on[1] ? |(pin_group_1 & pin_group_1_en)
                         : quiet_level(pin_irq_control[`SENSE_01_HI:`SENSE_01_LO], 1'b0);
   assign group_any[2] = group_on[2] ? |(pin_group_2 & pin_group_2_en)
                         : quiet_level(pin_irq_control[`SENSE_23_HI:`SENSE_23_LO],
                                       pin_irq_control[`POL_B_BIT]);
   assign group_any[3] = group_on[3] ? |(pin_group_3 & pin_group_3_en)
                         : quiet_level(pin_irq_control[`SENSE_23_HI:`SENSE_23_LO], 1'b0);

   // Groups 1 and 3 have no polarity bit
   pin_group_sense u_group_0 (
      .hclk(hclk), .hresetn(hresetn), .pin_any(group_any[0]),
      .sense(sense_t'(pin_irq_control[`SENSE_01_HI:`SENSE_01_LO])),
      .invert(pin_irq_control[`POL_A_BIT]), .clear(group_clear[0]),
      .pending(group_pend[0])); // [R18] [R23]
   pin_group_sense u_group_1 (
      .hclk(hclk), .hresetn(hresetn), .pin_any(group_any[1]),
      .sense(sense_t'(pin_irq_control[`SENSE_01_HI:`SENSE_01_LO])),
      .invert(1'b0), .clear(group_clear[1]), .pending(group_pend[1])); // [R18]
   pin_group_sense u_group_2 (
      .hclk(hclk), .hresetn(hresetn), .pin_any(group_any[2]),
      .sense(sense_t'(pin_irq_control[`SENSE_23_HI:`SENSE_23_LO])),
      .invert(pin_irq_control[`POL_B_BIT]), .clear(group_clear[2]),
      .pending(group_pend[2])); // [R18] [R23]
   pin_group_sense u_group_3 (
      .hclk(hclk), .hresetn(hresetn), .pin_any(group_any[3]),
      .sense(sense_t'(pin_irq_control[`SENSE_23_HI:`SENSE_23_LO])),
      .invert(1'b0), .clear(group_clear[3]), .pending(group_pend[3])); // [R18]

   // Top pin edge, direction set by its edge select; the enable gates it at the pending latch
   assign top_edge = pin_irq_control[`TOP_EDGE_BIT] ? (top_level_pin_irq & ~top_prev)
                                                    : (~top_level_pin_irq & top_prev);

   // Fixed-priority pendings; a new event beats the ack clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         top_prev <= 1'b0;
         top_pend <= 1'b0;
         trap_pend <= 1'b0;
         reset_pend <= 1'b1;
      end else begin
         top_prev <= top_level_pin_irq;
         if (top_edge && pin_irq_control[`TOP_EN_BIT]) begin
            top_pend <= 1'b1; // [R24]
         end else if (irq_ack && irq_kind == SRC_TOP) begin
            top_pend <= 1'b0;
         end
         if (trap_instr) begin
            trap_pend <= 1'b1;
         end else if (irq_ack && irq_kind == SRC_TRAP) begin
            trap_pend <= 1'b0;
         end
         if (irq_ack && irq_kind == SRC_RESET) begin
            reset_pend <= 1'b0;
         end
      end
   end

   // Maskable pending lines; bit 0 is the top pin and never competes here
   assign vec_pend = {periph_req, group_pend & group_on,
                      clock_time_base | safe_oscillator_monitor, 1'b0}; // [R11] [R17]

   // A raised level on a still-pending serviced vector wins again here
   always_comb begin
      found_vec = 1'b0;
      best_num = 4'h0;
      best_rank = 2'h0;
      for (int v = `NUM_VECTORS - 1; v >= 1; v--) begin
         if (vec_pend[v]
             && level_rank(level_of(vector_level_regs, 4'(v))) > cur_rank
             && (!found_vec || level_rank(level_of(vector_level_regs, 4'(v))) >= best_rank))
         begin
            found_vec = 1'b1; // [R26] [R12]
            best_num = 4'(v); // [R15]
            best_rank = level_rank(level_of(vector_level_regs, 4'(v)));
         end
      end
      if (reset_pend) begin
         next_kind = SRC_RESET;
      end else if (trap_pend) begin
         next_kind = SRC_TRAP; // [R5]
      end else if (top_pend) begin
         next_kind = SRC_TOP; // [R5]
      end else if (found_vec) begin
         next_kind = SRC_VECTOR;
      end else begin
         next_kind = SRC_NONE;
      end
      case (next_kind)
         SRC_RESET: next_addr = `VEC_RESET; // [R15]
         SRC_TRAP: next_addr = `VEC_TRAP;
         SRC_TOP: next_addr = `VEC_TOP;
         SRC_VECTOR: next_addr = vec_addr(best_num);
         default: next_addr = `VEC_TOP;
      endcase
   end

   // Registered request; dropped for one cycle after each ack
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_req <= 1'b0;
         irq_kind <= SRC_NONE;
         irq_vector_num <= 4'h0;
         irq_vector_addr <= `VEC_RESET;
      end else if (irq_ack) begin
         irq_req <= 1'b0;
         irq_kind <= SRC_NONE;
      end else begin
         irq_req <= next_kind != SRC_NONE;
         irq_kind <= next_kind;
         irq_vector_num <= (next_kind == SRC_VECTOR) ? best_num : 4'h0;
         irq_vector_addr <= next_addr;
      end
   end

   // Condition flags; service entry outranks instruction updates
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_condition_flags <= `FLAGS_RESET; // [R2]
      end else if (irq_ack && irq_kind == SRC_VECTOR) begin
         cpu_condition_flags[`FLAG_LEVEL_HIGH] <= served_level[1]; // [R3]
         cpu_condition_flags[`FLAG_LEVEL_LOW] <= served_level[0];
      end else if (irq_ack && irq_kind != SRC_NONE) begin
         cpu_condition_flags[`FLAG_LEVEL_HIGH] <= 1'(`LVL_OFF >> 1); // [R10]
         cpu_condition_flags[`FLAG_LEVEL_LOW] <= 1'(`LVL_OFF);
      end else if (irq_return_instr || pop_condition_flags) begin
         cpu_condition_flags <= stacked_flags; // [R4] [R14]
      end else if (disable_irq_instr) begin
         cpu_condition_flags[`FLAG_LEVEL_HIGH] <= 1'(`LVL_OFF >> 1); // [R4] [R14]
         cpu_condition_flags[`FLAG_LEVEL_LOW] <= 1'(`LVL_OFF);
      end else if (enable_irq_instr || halt_instr || wait_for_irq_instr) begin
         cpu_condition_flags[`FLAG_LEVEL_HIGH] <= 1'(`LVL_MAIN >> 1); // [R4] [R14]
         cpu_condition_flags[`FLAG_LEVEL_LOW] <= 1'(`LVL_MAIN);
      end else if (alu_flags_we) begin
         cpu_condition_flags[7:6] <= alu_flags[7:6];
         cpu_condition_flags[4] <= alu_flags[4];
         cpu_condition_flags[2:0] <= alu_flags[2:0];
      end
   end

   // Jump conditions and halt wake, one cycle behind the flags
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         jump_if_masked <= 1'b1;
         jump_if_unmasked <= 1'b0;
         wake_from_halt <= 1'b0;
      end else begin
         jump_if_masked <= cur_level == `LVL_OFF; // [R13]
         jump_if_unmasked <= cur_level != `LVL_OFF; // [R13]
         wake_from_halt <= reset_pend | top_pend | (|(group_pend & group_on)) | periph_req[`V_CAN]
                           | (periph_req[`V_SPI] & spi_slave_mode)
                           | (periph_req[`V_PWM] & pwm_external_clock) // [R16]
                           | (vec_pend[`V_TIME_BASE] & halt_keeps_time_base); // [R17]
      end
   end

   // Checks
   a_enable_main: assert property (@(posedge hclk) disable iff (!hresetn)
      enable_irq_instr && !irq_ack && !irq_return_instr && !pop_condition_flags
      && !disable_irq_instr |=> cur_level == `LVL_MAIN) else $error("enable missed"); // [R4]
   a_disable_off: assert property (@(posedge hclk) disable iff (!hresetn)
      disable_irq_instr && !irq_ack && !irq_return_instr && !pop_condition_flags
      |=> cur_level == `LVL_OFF) else $error("disable missed"); // [R4]
   a_entry_level: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_ack && irq_kind == SRC_VECTOR |=> cur_level == $past(served_level))
      else $error("entry level wrong"); // [R3]
   a_fixed_off: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_ack && irq_kind inside {SRC_RESET, SRC_TRAP, SRC_TOP} |=> cur_level == `LVL_OFF)
      else $error("fixed source level wrong"); // [R10]
   a_off_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_req && irq_kind == SRC_VECTOR |-> $past(cur_level) != `LVL_OFF)
      else $error("maskable taken at level 3"); // [R5]
   a_jump_masked: assert property (@(posedge hclk) disable iff (!hresetn)
      jump_if_masked |-> $past(cur_level) == `LVL_OFF) else $error("jump flag wrong"); // [R13]
   a_jump_pair: assert property (@(posedge hclk) disable iff (!hresetn)
      jump_if_masked != jump_if_unmasked) else $error("jump pair clash"); // [R13]
   a_no_main_field: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 !(vector_level_regs[0][1:0] == `LVL_MAIN || vector_level_regs[1][5:4] == `LVL_MAIN
      || vector_level_regs[3][3:2] == `LVL_MAIN)) else $error("level 0 stored"); // [R9]
   a_vector_addr: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_req && irq_kind == SRC_VECTOR |-> irq_vector_addr == vec_addr(irq_vector_num))
      else $error("vector address wrong"); // [R15]

   c_vector_entry: cover property (@(posedge hclk) disable iff (!hresetn)
      irq_ack && irq_kind == SRC_VECTOR);
   c_nested: cover property (@(posedge hclk) disable iff (!hresetn)
      irq_ack && irq_kind == SRC_VECTOR && cur_level != `LVL_MAIN);
   c_top_entry: cover property (@(posedge hclk) disable iff (!hresetn)
      irq_ack && irq_kind == SRC_TOP);
   c_wake: cover property (@(posedge hclk) disable iff (!hresetn) wake_from_halt);
endmodule // nested_priority_interrupt_ctrl

//--- verilog/pin_group_sense.sv
// Edge and level detector with pending latch for one external pin group
module pin_group_sense
   import nested_irq_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Combined pin level and its sensitivity
   input wire logic pin_any,
   input wire sense_t sense,
   input wire logic invert,
   // Pending control
   input wire logic clear,
   output logic pending
);
   logic pin_prev;
   logic rise;
   logic fall;
   logic hit;

   // Last pin level, for edges
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_prev <= 1'b0;
      end else begin
         pin_prev <= pin_any;
      end
   end

   assign rise = pin_any & ~pin_prev;
   assign fall = ~pin_any & pin_prev;

   // Inversion swaps edges and turns low level into high level
   always_comb begin
      case (sense)
         SENSE_FALL_LOW: hit = invert ? (rise | pin_any) : (fall | ~pin_any); // [R22] [R23]
         SENSE_RISE: hit = invert ? fall : rise; // [R22] [R23]
         SENSE_FALL: hit = invert ? rise : fall; // [R22] [R23]
         SENSE_BOTH: hit = rise | fall; // [R22]
         default: hit = 1'b0;
      endcase
   end

   // Set wins over clear, so an edge on the ack cycle is kept
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pending <= 1'b0;
      end else if (hit) begin
         pending <= 1'b1; // [R25]
      end else if (clear) begin
         pending <= 1'b0; // [R25] [R21]
      end
   end
endmodule // pin_group_sense
